// file: verilog/adcr_top.sv
// Purpose: Control and result registers of a 10-bit successive
//          approximation converter, facing software and the engine.
// Assumes: The engine runs off this clock and the tick given here.
// Notes: Result registers have no reset.
//        Start needs the converter enabled by an earlier write.
//        Completion wins over a clear arriving in the same cycle.
//        Reserved reference codes pass through on ref_code.
//        The divider runs only while enabled and not on the RC clock.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "adcr_cfg.svh"

module adcr_top (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Software register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Conversion engine side
  input wire logic eng_done,
  input wire logic [9:0] eng_result,
  input wire logic [3:0] eng_bits,
  // Analog routing and engine requests, all registered
  output adcr_pkg::adcr_route_t route,
  output adcr_pkg::adcr_eng_req_t eng_req,
  output logic conversion_done_flag
);

  // Sequencer and control storage
  adcr_pkg::adcr_state_t state;
  adcr_pkg::adcr_state_t next_state;
  adcr_pkg::adcr_ctrl0_t ctrl0;
  adcr_pkg::adcr_ctrl0_t next_ctrl0;
  adcr_pkg::adcr_ctrl1_t ctrl1;
  adcr_pkg::adcr_ctrl1_t next_ctrl1;

  // Registered outputs and their next values
  adcr_pkg::adcr_route_t next_route;
  adcr_pkg::adcr_eng_req_t next_eng_req;
  logic [7:0] next_reg_rdata;
  logic next_conversion_done_flag;

  // Result storage, kept through reset
  logic [7:0] result_high;
  logic [7:0] next_result_high;
  logic [7:0] result_low;
  logic [7:0] next_result_low;

  // Conversion clock divider
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic [5:0] div_lim;
  logic div_tick;

  // Register write decode
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_res_hi;
  logic wr_res_lo;

  // Start, stop and result loading
  logic go_req;
  logic go_clear;
  logic load;
  logic [9:0] load_val;
  logic start_evt;
  logic stop_evt;

  // Channel class and clock source decode
  logic ch_ext_lo;
  logic ch_ext_hi;
  logic rc_sel;

  // Fill bits not yet converted with the last bit converted;
  // bits counts converted bits from the top, zero gives all zero
  // and ten or more passes the raw result through
  function automatic logic [9:0] adcr_fill(
    input logic [9:0] raw,
    input logic [3:0] bits
  );
    logic [9:0] f;
    logic last;
    f = raw;
    last = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if ((10 - i) <= int'(bits)) begin
        last = raw[i];
      end else begin
        f[i] = last;
      end
    end
    return f;
  endfunction : adcr_fill

  // Decode of software writes
  always_comb begin
    wr_ctrl0 = reg_wr && (reg_addr == `ADCR_OFS_CTRL0);
    wr_ctrl1 = reg_wr && (reg_addr == `ADCR_OFS_CTRL1);
    wr_res_hi = reg_wr && (reg_addr == `ADCR_OFS_RES_HI);
    wr_res_lo = reg_wr && (reg_addr == `ADCR_OFS_RES_LO);
    // Start only honoured on an already enabled converter
    go_req = wr_ctrl0 && reg_wdata[`ADCR_C0_GO_BIT] &&
      ctrl0.converter_enable;
    // Dropping the enable counts as a clear of the go bit
    go_clear = wr_ctrl0 && (!reg_wdata[`ADCR_C0_GO_BIT] ||
      !reg_wdata[`ADCR_C0_EN_BIT]);
  end

  // Control registers; unimplemented bits are simply not stored,
  // so they read back as zero whatever software writes there.
  // The go bit is not stored either: it is the sequencer's state.
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    if (wr_ctrl0) begin
      // Bit 7 is not stored
      next_ctrl0.channel_selector =
        reg_wdata[`ADCR_C0_CH_MSB:`ADCR_C0_CH_LSB];
      next_ctrl0.converter_enable = reg_wdata[`ADCR_C0_EN_BIT];
    end
    if (wr_ctrl1) begin
      // Bits 3..2 are not stored
      next_ctrl1.justify_select = reg_wdata[`ADCR_C1_FMT_BIT];
      next_ctrl1.conv_clock_select =
        reg_wdata[`ADCR_C1_CLK_MSB:`ADCR_C1_CLK_LSB];
      next_ctrl1.pos_reference_select =
        reg_wdata[`ADCR_C1_REF_MSB:`ADCR_C1_REF_LSB];
    end
  end

  // Every reset clears the control bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl0 <= adcr_pkg::adcr_ctrl0_t'(`ADCR_CTRL0_RST);
      ctrl1 <= adcr_pkg::adcr_ctrl1_t'(`ADCR_CTRL1_RST);
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
    end
  end

  // Conversion sequence; a stop waits for the engine's done so the
  // partial result is loaded, and the go bit reads zero from the
  // clear onwards
  always_comb begin
    next_state = state;
    load = 1'b0;
    next_conversion_done_flag = 1'b0;
    unique case (state)
      adcr_pkg::adcr_idle: begin
        // A start on a disabled converter was already filtered out
        if (go_req) begin
          next_state = adcr_pkg::adcr_busy;
        end
      end
      adcr_pkg::adcr_busy: begin
        if (eng_done) begin
          // Completion wins over a clear in the same cycle
          next_state = adcr_pkg::adcr_idle;
          load = 1'b1;
          next_conversion_done_flag = 1'b1;
        end else if (go_clear) begin
          next_state = adcr_pkg::adcr_stop;
        end
      end
      adcr_pkg::adcr_stop: begin
        // No done flag for a stopped conversion
        if (eng_done) begin
          next_state = adcr_pkg::adcr_idle;
          load = 1'b1;
        end
      end
    endcase
  end

  // Reset terminates any pending conversion
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= adcr_pkg::adcr_idle;
      conversion_done_flag <= 1'b0;
    end else begin
      state <= next_state;
      conversion_done_flag <= next_conversion_done_flag;
    end
  end

  // Engine event and channel class decode
  always_comb begin
    start_evt = (state == adcr_pkg::adcr_idle) &&
      (next_state == adcr_pkg::adcr_busy);
    stop_evt = (state == adcr_pkg::adcr_busy) &&
      (next_state == adcr_pkg::adcr_stop);
    ch_ext_lo = ctrl0.channel_selector <= `ADCR_CH_EXT_LO_LAST;
    ch_ext_hi = (ctrl0.channel_selector >= `ADCR_CH_EXT_HI_FIRST) &&
      (ctrl0.channel_selector <= `ADCR_CH_EXT_HI_LAST);
    // Codes 011 and 111 share the low bits, so only those are compared
    rc_sel = ctrl1.conv_clock_select[1:0] == `ADCR_CLK_RC_LOW;
  end

  // Result registers, no reset so contents survive it.
  // A software write to a result byte is masked by the format in
  // force at that time; a later format change does not rewrite it.
  always_comb begin
    next_result_high = result_high;
    next_result_low = result_low;
    load_val = adcr_fill(eng_result, eng_bits);
    if (ctrl1.justify_select == `ADCR_FMT_RIGHT) begin
      // Right format: high byte holds only result bits 9..8
      if (wr_res_hi) begin
        next_result_high = reg_wdata & `ADCR_MASK_RIGHT_HI;
      end
      if (wr_res_lo) begin
        next_result_low = reg_wdata;
      end
      if (load) begin
        next_result_high = {6'h00, load_val[9:8]};
        next_result_low = load_val[7:0];
      end
    end else begin
      // Left format: low byte holds only result bits 1..0
      if (wr_res_hi) begin
        next_result_high = reg_wdata;
      end
      if (wr_res_lo) begin
        next_result_low = reg_wdata & `ADCR_MASK_LEFT_LO;
      end
      if (load) begin
        next_result_high = load_val[9:2];
        next_result_low = {load_val[1:0], 6'h00};
      end
    end
  end

  always_ff @(posedge clock) begin
    result_high <= next_result_high;
    result_low <= next_result_low;
  end

  // Read port, data valid only in the cycle after the strobe.
  // The go bit is read from the sequencer, so it shows one exactly
  // while a conversion runs and not while a stop is pending.
  always_comb begin
    next_reg_rdata = `ADCR_ZERO_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADCR_OFS_CTRL0: begin
          next_reg_rdata = {1'b0, ctrl0.channel_selector,
            (state == adcr_pkg::adcr_busy),
            ctrl0.converter_enable};
        end
        `ADCR_OFS_CTRL1: begin
          next_reg_rdata = {ctrl1.justify_select,
            ctrl1.conv_clock_select, 2'h0,
            ctrl1.pos_reference_select};
        end
        `ADCR_OFS_RES_HI: begin
          next_reg_rdata = result_high;
        end
        `ADCR_OFS_RES_LO: begin
          next_reg_rdata = result_low;
        end
      endcase
    end
  end

  // Read data returns to zero when no read is pending
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= `ADCR_ZERO_BYTE;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Conversion clock divider; tick period equals the divisor, as
  // the count runs from zero up to the limit and then restarts.
  // Held at zero while disabled or on the RC clock, so no tick.
  always_comb begin
    unique case (ctrl1.conv_clock_select)
      `ADCR_CLK_DIV2: div_lim = `ADCR_LIM_DIV2;
      `ADCR_CLK_DIV4: div_lim = `ADCR_LIM_DIV4;
      `ADCR_CLK_DIV8: div_lim = `ADCR_LIM_DIV8;
      `ADCR_CLK_DIV16: div_lim = `ADCR_LIM_DIV16;
      `ADCR_CLK_DIV32: div_lim = `ADCR_LIM_DIV32;
      `ADCR_CLK_DIV64: div_lim = `ADCR_LIM_DIV64;
      default: div_lim = `ADCR_LIM_DIV2;
    endcase
    next_div_cnt = `ADCR_CNT_ZERO;
    div_tick = 1'b0;
    if (ctrl0.converter_enable && !rc_sel) begin
      if (div_cnt >= div_lim) begin
        div_tick = 1'b1;
      end else begin
        next_div_cnt = 6'(div_cnt + `ADCR_CNT_ONE);
      end
    end
  end

  // Divider count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_cnt <= `ADCR_CNT_ZERO;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Channel routing and engine requests
  always_comb begin
    next_route = '0;
    // External index is the low four code bits of a routed channel
    if (ch_ext_lo || ch_ext_hi) begin
      next_route.ext_connect = 1'b1;
      next_route.ext_index = ctrl0.channel_selector[3:0];
    end
    next_route.temp_connect =
      (ctrl0.channel_selector == `ADCR_CH_TEMP);
    next_route.fvr_connect =
      (ctrl0.channel_selector == `ADCR_CH_FVR);
    next_eng_req.power = ctrl0.converter_enable;
    next_eng_req.rc_clock = ctrl0.converter_enable && rc_sel;
    next_eng_req.conv_tick = div_tick;
    next_eng_req.start = start_evt;
    next_eng_req.stop = stop_evt;
    next_eng_req.ref_ext_pin =
      (ctrl1.pos_reference_select == `ADCR_REF_PIN);
    next_eng_req.ref_code = ctrl1.pos_reference_select;
  end

  // All engine-facing outputs come straight from flip-flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      route <= '0;
      eng_req <= '0;
    end else begin
      route <= next_route;
      eng_req <= next_eng_req;
    end
  end

endmodule : adcr_top

// file: inc/adcr_cfg.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          converter control register block.
// Assumes: Eight-bit register port with a two-bit word address.
// Notes: Included by bare name.
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH

`define ADCR_OFS_CTRL0 2'h0
`define ADCR_OFS_CTRL1 2'h1
`define ADCR_OFS_RES_HI 2'h2
`define ADCR_OFS_RES_LO 2'h3

`define ADCR_C0_EN_BIT 0
`define ADCR_C0_GO_BIT 1
`define ADCR_C0_CH_LSB 2
`define ADCR_C0_CH_MSB 6
`define ADCR_C1_REF_LSB 0
`define ADCR_C1_REF_MSB 1
`define ADCR_C1_CLK_LSB 4
`define ADCR_C1_CLK_MSB 6
`define ADCR_C1_FMT_BIT 7

`define ADCR_CTRL0_RST 8'h00
`define ADCR_CTRL1_RST 8'h00
`define ADCR_ZERO_BYTE 8'h00

`define ADCR_CH_EXT_LO_LAST 5'h04
`define ADCR_CH_EXT_HI_FIRST 5'h08
`define ADCR_CH_EXT_HI_LAST 5'h0d
`define ADCR_CH_TEMP 5'h1d
`define ADCR_CH_FVR 5'h1f

`define ADCR_REF_VDD 2'h0
`define ADCR_REF_PIN 2'h2
`define ADCR_FMT_RIGHT 1'b1

`define ADCR_CLK_RC_LOW 2'h3
`define ADCR_CLK_DIV2 3'h0
`define ADCR_CLK_DIV4 3'h4
`define ADCR_CLK_DIV8 3'h1
`define ADCR_CLK_DIV16 3'h5
`define ADCR_CLK_DIV32 3'h2
`define ADCR_CLK_DIV64 3'h6
`define ADCR_LIM_DIV2 6'h01
`define ADCR_LIM_DIV4 6'h03
`define ADCR_LIM_DIV8 6'h07
`define ADCR_LIM_DIV16 6'h0f
`define ADCR_LIM_DIV32 6'h1f
`define ADCR_LIM_DIV64 6'h3f
`define ADCR_CNT_ZERO 6'h00
`define ADCR_CNT_ONE 6'h01

`define ADCR_MASK_LEFT_LO 8'hc0
`define ADCR_MASK_RIGHT_HI 8'h03
`define ADCR_FULL_BITS 4'ha

`endif

// file: inc/adcr_pkg.sv
// Purpose: Types of the converter control register block.
// Assumes: Constants come from adcr_cfg.svh.
// Notes: Nothing here is imported; users write adcr_pkg::name.
package adcr_pkg;

  typedef enum logic [1:0] {
    adcr_idle,
    adcr_busy,
    adcr_stop
  } adcr_state_t;

  typedef struct packed {
    logic [4:0] channel_selector;
    logic converter_enable;
  } adcr_ctrl0_t;

  typedef struct packed {
    logic justify_select;
    logic [2:0] conv_clock_select;
    logic [1:0] pos_reference_select;
  } adcr_ctrl1_t;

  typedef struct packed {
    logic ext_connect;
    logic [3:0] ext_index;
    logic temp_connect;
    logic fvr_connect;
  } adcr_route_t;

  typedef struct packed {
    logic power;
    logic rc_clock;
    logic conv_tick;
    logic start;
    logic stop;
    logic ref_ext_pin;
    logic [1:0] ref_code;
  } adcr_eng_req_t;

endpackage : adcr_pkg

// file: dv/adcr_properties.sv
// Purpose: Port-level checks of the converter register block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound into adcr_top after endmodule.
`timescale 1ns/10ps
`include "adcr_cfg.svh"

module adcr_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic eng_done,
  input wire adcr_pkg::adcr_route_t route,
  input wire adcr_pkg::adcr_eng_req_t eng_req,
  input wire logic conversion_done_flag
);
  wire logic [4:0] ch = reg_wdata[6:2];
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Write not followed by another write to the same place
  sequence wr_alone(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  sequence rd_of(a);
    reg_rd && reg_addr == a;
  endsequence

  chk_ctrl0_rsvd: assert property (rd_of(`ADCR_OFS_CTRL0) |=>
    !reg_rdata[7]) else $error("control 0 bit 7 not zero");
  chk_ctrl1_rsvd: assert property (rd_of(`ADCR_OFS_CTRL1) |=>
    reg_rdata[3:2] == 2'h0) else $error("control 1 bits 3-2 not zero");
  chk_power_follow: assert property (wr_alone(`ADCR_OFS_CTRL0) |->
    ##1 eng_req.power == $past(reg_wdata[0], 2))
    else $error("power does not follow enable");
  chk_route_ext: assert property (wr_alone(`ADCR_OFS_CTRL0) |->
    ##1 route.ext_connect == ($past(ch, 2) <= `ADCR_CH_EXT_LO_LAST ||
    ($past(ch, 2) >= `ADCR_CH_EXT_HI_FIRST &&
    $past(ch, 2) <= `ADCR_CH_EXT_HI_LAST)))
    else $error("external route wrong");
  chk_route_int: assert property (wr_alone(`ADCR_OFS_CTRL0) |->
    ##1 {route.temp_connect, route.fvr_connect} ==
    {$past(ch, 2) == `ADCR_CH_TEMP, $past(ch, 2) == `ADCR_CH_FVR})
    else $error("internal route wrong");
  chk_ref_follow: assert property (wr_alone(`ADCR_OFS_CTRL1) |->
    ##1 eng_req.ref_code == $past(reg_wdata[1:0], 2) &&
    eng_req.ref_ext_pin == ($past(reg_wdata[1:0], 2) == `ADCR_REF_PIN))
    else $error("reference select wrong");
  chk_rc_clock: assert property (wr_alone(`ADCR_OFS_CTRL1) |->
    ##1 eng_req.rc_clock == (eng_req.power &&
    $past(reg_wdata[5:4], 2) == `ADCR_CLK_RC_LOW))
    else $error("rc clock select wrong");
  chk_tick_gate: assert property (eng_req.conv_tick |->
    eng_req.power && !eng_req.rc_clock) else $error("tick while gated");
  chk_start_pulse: assert property (eng_req.start |=>
    !eng_req.start) else $error("start longer than one cycle");
  chk_flag_cause: assert property (conversion_done_flag |->
    $past(eng_done)) else $error("done flag without engine done");
endmodule : adcr_properties

bind adcr_top adcr_properties i_adcr_properties (.clock(clock),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .eng_done(eng_done), .route(route), .eng_req(eng_req),
  .conversion_done_flag(conversion_done_flag));

// file: dv/adcr_top_test.sv
// Purpose: Register-level test of the converter control block.
// Assumes: Engine side driven directly by this bench.
// Notes: Every wait is bounded; the run ends in print_verdict.
`timescale 1ns/10ps
`include "adcr_cfg.svh"

module adcr_top_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic eng_done = 1'b0;
  logic [9:0] eng_result = 10'h000;
  logic [3:0] eng_bits = 4'h0;
  adcr_pkg::adcr_route_t route;
  adcr_pkg::adcr_eng_req_t eng_req;
  logic conversion_done_flag;
  logic ext;
  int errors = 0;
  int comparisons = 0;
  int n;
  int div[8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  always #50 clock = ~clock;

  adcr_top i_adcr_top (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_done(eng_done),
    .eng_result(eng_result), .eng_bits(eng_bits), .route(route),
    .eng_req(eng_req), .conversion_done_flag(conversion_done_flag));

  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rc

  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  // Sel 0 tick, 1 start, 2 stop; n counts edges waited
  task automatic wait_for(input int sel);
    for (n = 0; n < 200; n++) begin
      #1;
      if (sel == 0 ? eng_req.conv_tick :
          sel == 1 ? eng_req.start : eng_req.stop) break;
      @(posedge clock);
    end
    if (n == 200) begin
      errors++;
      print_verdict();
    end
  endtask : wait_for

  task automatic conv(input logic [7:0] c1, input logic [9:0] r,
                      input logic [3:0] b);
    logic [9:0] v;
    wr(2'h1, c1);
    wr(2'h0, 8'h05);
    wr(2'h0, 8'h07);
    wait_for(1);
    rc(2'h0, 8'h07);
    if (b != `ADCR_FULL_BITS) begin
      wr(2'h0, 8'h05);
      wait_for(2);
      rc(2'h0, 8'h05);
    end
    @(posedge clock);
    eng_done <= 1'b1;
    eng_result <= r;
    eng_bits <= b;
    @(posedge clock);
    eng_done <= 1'b0;
    #1;
    check(8'(conversion_done_flag), 8'(b == `ADCR_FULL_BITS));
    rc(2'h0, 8'h05);
    v = r;
    for (int i = 0; i < 10; i++) begin
      if (i < 10 - b) v[i] = (b == 0) ? 1'b0 : r[10 - b];
    end
    if (c1[7]) begin
      rc(2'h2, {6'h00, v[9:8]});
      rc(2'h3, v[7:0]);
    end else begin
      rc(2'h2, v[9:2]);
      rc(2'h3, {v[1:0], 6'h00});
    end
  endtask : conv

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rc(2'h0, `ADCR_CTRL0_RST);
    rc(2'h1, `ADCR_CTRL1_RST);
    wr(2'h0, 8'hff);
    rc(2'h0, 8'h7d);
    wr(2'h1, 8'hff);
    rc(2'h1, 8'hf3);
    for (int c = 0; c < 32; c++) begin
      wr(2'h0, 8'(c << 2));
      settle();
      ext = (c <= 4) || (c >= 8 && c <= 13);
      check(8'(route.ext_connect), 8'(ext));
      if (ext) check(8'(route.ext_index), 8'(c));
      check(8'({route.temp_connect, route.fvr_connect}),
            8'({c == 29, c == 31}));
    end
    check(8'(eng_req.power), 8'h00);
    wr(2'h0, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(2'h1, 8'(k << 4 | k % 4));
      settle();
      check(8'(eng_req.ref_code), 8'(k % 4));
      check(8'(eng_req.ref_ext_pin), 8'(k % 4 == 2));
      check(8'(eng_req.rc_clock), 8'(k % 4 == 3));
      if (k % 4 != 3) begin
        wait_for(0);
        @(posedge clock);
        wait_for(0);
        check(8'(n + 1), 8'(div[k]));
      end
    end
    conv(8'h80, 10'h2d5, 4'ha);
    conv(8'h00, 10'h2d5, 4'ha);
    conv(8'h80, 10'h2b4, 4'h5);
    conv(8'h00, 10'h3ff, 4'h0);
    wr(2'h3, 8'hff);
    rc(2'h3, 8'hc0);
    wr(2'h1, 8'h80);
    wr(2'h2, 8'hff);
    rc(2'h2, 8'h03);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rc(2'h1, 8'h00);
    rc(2'h2, 8'h03);
    rc(2'h3, 8'hc0);
    print_verdict();
  end
endmodule : adcr_top_test
